// ===== hdl/dkif_pkg.sv
// Constants and types for the drive seek and record link
//
// What this block does
// [R1] Ready only after supplies, speed, recalibration
// [R2] Supply or speed fault holds ready off
// [R3] Ready expected within 25 s of power
// [R4] Speed off by 2% locks, stops, latches; in DS_RECAL it drops to DS_OFF without lock or latch
// [R5] Seek done only once heads settled
// [R6] Controller never writes without seek done
// [R7] One step pulse moves exactly one track
// [R8] Direction high outward, low inward
// [R9] Outer cylinder flag at cylinder 0
// [R10] Record gate low writes, high reads
// [R11] Each record data rise makes one reversal
// [R12] Each read reversal shown as playback rise
// [R13] Write problems raise the record fault
// [R14] Write current while reading raises fault
// [R15] Faulted drive ignores all further commands
// [R16] Deselect rechecks fault, clears if gone
// [R17] Preamp mode select high write, low read
// [R18] Unsafe flag: writing without current or data
// [R19] Commands obeyed only while unit selected
// [R20] Revolution mark once per turn, 16.67 ms
// [R21] Four active-low head lines, idle head 0
// [R22] Controller steps only selected and ready
package dkif_pkg;

  // ---------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------
  localparam longint unsigned CLK_HZ    = 64'h0000_0000_05F5_E100;
  localparam longint unsigned NS_PER_S  = 64'h0000_0000_3B9A_CA00;
  localparam longint unsigned US_PER_S  = 64'h0000_0000_000F_4240;

  // One turn 16670 us, tolerance 2 percent
  localparam longint unsigned REV_US    = 64'h0000_0000_0000_411E;
  localparam int unsigned     SPEED_PCT = 32'h0000_0002;
  localparam int unsigned     REV_CYC   =
    32'(REV_US * CLK_HZ / US_PER_S);

  // Ready within 25 s
  localparam longint unsigned START_S   = 64'h0000_0000_0000_0019;
  localparam int unsigned     START_CYC = 32'(START_S * CLK_HZ);

  // Step 500 ns low, 2000 ns gap; minimums round up
  localparam longint unsigned STEP_W_NS   = 64'h0000_0000_0000_01F4;
  localparam longint unsigned STEP_GAP_NS = 64'h0000_0000_0000_07D0;
  localparam int unsigned     STEP_W_CYC  =
    32'((STEP_W_NS * CLK_HZ + NS_PER_S - 64'h1) / NS_PER_S);
  localparam int unsigned     STEP_GAP_CYC =
    32'((STEP_GAP_NS * CLK_HZ + NS_PER_S - 64'h1) / NS_PER_S);

  // Gate this long with no data edge means no data
  localparam int unsigned     NODATA_CYC = 32'h0000_0100;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int              CYL_W   = 32'h0000_000A;
  localparam int unsigned     N_HEADS = 32'h0000_0008;

  // Idle controller lines:
  // {sel_n, step_n, move_in_n, head_sel_n[3:0], gate_n, p, m}
  localparam logic [9:0]      LINK_IN_IDLE = 10'h3FD;
  // Idle drive lines: {rdy,skd,out0,flt,mark,p,m}
  localparam logic [6:0]      DRV_IN_IDLE  = 7'h7D;

  // ---------------------------------------------------------------
  // Controller register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SEEK = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_FLUX = 8'h0C;
  localparam logic [7:0] REG_REVS = 8'h10;

  localparam int CTRL_SEL  = 32'h0;
  localparam int CTRL_WEN  = 32'h1;
  localparam int CTRL_HEAD = 32'h2;
  localparam int SEEK_IN   = 32'h10;
  localparam int STAT_RDY  = 32'h0;
  localparam int STAT_SKD  = 32'h1;
  localparam int STAT_OUT0 = 32'h2;
  localparam int STAT_FLT  = 32'h3;
  localparam int STAT_BUSY = 32'h4;
  localparam int STAT_SFL  = 32'h5;

  // ---------------------------------------------------------------
  // Drive sequencing states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    DS_OFF   = 5'h01,
    DS_SPIN  = 5'h02,
    DS_RECAL = 5'h04,
    DS_READY = 5'h08,
    DS_SHUT  = 5'h10
  } dkif_dstate_t;

endpackage

// ===== hdl/dkif_link_if.sv
// Link between the drive controller and the drive
`timescale 1ns/100ps
interface dkif_link_if;
  logic       unit_select_n;
  logic       step_n;
  logic       move_in_n;
  logic [3:0] head_sel_n;
  logic       record_gate_n;
  logic       record_data_p;
  logic       record_data_m;
  logic       drive_ready_n;
  logic       seek_done_n;
  logic       outer_cylinder_n;
  logic       record_fault_n;
  logic       revolution_mark_n;
  logic       playback_data_p;
  logic       playback_data_m;

  modport drive (
    input  unit_select_n, step_n, move_in_n, head_sel_n,
           record_gate_n, record_data_p, record_data_m,
    output drive_ready_n, seek_done_n, outer_cylinder_n,
           record_fault_n, revolution_mark_n,
           playback_data_p, playback_data_m
  );

  modport ctrl (
    output unit_select_n, step_n, move_in_n, head_sel_n,
           record_gate_n, record_data_p, record_data_m,
    input  drive_ready_n, seek_done_n, outer_cylinder_n,
           record_fault_n, revolution_mark_n,
           playback_data_p, playback_data_m
  );
endinterface

// ===== hdl/dkif_sync.sv
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/100ps
module dkif_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// ===== hdl/dkif_drive.sv
// Drive end: sequencing, positioning, record and fault logic
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module dkif_drive #(
  parameter int unsigned REV_CYC = dkif_pkg::REV_CYC,
  parameter int unsigned N_HEADS = dkif_pkg::N_HEADS,
  parameter int          CYL_W   = dkif_pkg::CYL_W
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  dkif_link_if.drive      link,
  input  wire logic       supply_good_i,
  input  wire logic       spindle_tick_i,
  input  wire logic       settled_i,
  input  wire logic       recal_done_i,
  input  wire logic       head_open_i,
  input  wire logic       head_short_i,
  input  wire logic       wr_current_ok_i,
  input  wire logic       off_track_i,
  input  wire logic       head_current_i,
  input  wire logic       wr_protect_i,
  input  wire logic       read_flux_i,
  output logic            motor_on_o,
  output logic            actuator_lock_o,
  output logic            recal_o,
  output logic            actuator_step_o,
  output logic            actuator_out_o,
  output logic [3:0]      head_o,
  output logic            preamp_mode_sel_o,
  output logic            write_flux_o,
  output logic            unsafe_current_flag_o
);
  localparam int unsigned REV_TOL =
    32'((64'(REV_CYC) * 64'(dkif_pkg::SPEED_PCT)) / 64'h64);
  localparam logic [31:0] REV_LO = 32'(REV_CYC - REV_TOL);
  localparam logic [31:0] REV_HI = 32'(REV_CYC + REV_TOL);
  localparam logic [15:0] ND_MAX = 16'(dkif_pkg::NODATA_CYC);
  localparam logic [CYL_W-1:0] CYL_MAX = '1;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [10:0] ms;
  logic [9:0]  ls;

  dkif_sync #(.W(11), .RST_VAL(11'h000)) u_msync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({supply_good_i, spindle_tick_i, settled_i, recal_done_i,
             head_open_i, head_short_i, wr_current_ok_i, off_track_i,
             head_current_i, wr_protect_i, read_flux_i}),
    .q_o   (ms)
  );

  dkif_sync #(.W(10), .RST_VAL(dkif_pkg::LINK_IN_IDLE)) u_lsync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({link.unit_select_n, link.step_n, link.move_in_n,
             link.head_sel_n, link.record_gate_n,
             link.record_data_p, link.record_data_m}),
    .q_o   (ls)
  );

  logic       s_supply, s_tick, s_settle, s_recal, s_open, s_short;
  logic       s_wcok, s_offtrk, s_hcur, s_wprot, s_flux;
  logic       sel_n, step_n, out_dir, gate_n, wd;
  logic [3:0] head_sel;

  assign {s_supply, s_tick, s_settle, s_recal, s_open, s_short,
          s_wcok, s_offtrk, s_hcur, s_wprot, s_flux} = ms;
  assign sel_n    = ls[9];
  assign step_n   = ls[8];
  assign out_dir  = ls[7];
  assign head_sel = ~ls[6:3];
  assign gate_n   = ls[2];
  assign wd       = ls[1] & ~ls[0];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dkif_pkg::dkif_dstate_t st;
    logic [31:0]      rev_cnt;
    logic             spd_good;
    logic [CYL_W-1:0] cyl;
    logic             busy;
    logic [15:0]      nd_cnt;
    logic             p_step, p_wd, p_flux, p_settle;
    logic             p_sel_n, p_tick, p_recal;
    logic             ready_n, skd_n, out0_n, flt_n, mark_n;
    logic             pb_p, pb_m;
    logic             motor, lock, recal, act_step, act_out;
    logic [3:0]       head;
    logic             preamp, wflux, unsafe;
  } dkif_drv_t;

  dkif_drv_t q, next_q;

  logic tick, step_fall, wd_rise, settle_rise, recal_rise, desel;
  logic active, attempt, nodata, inv_head, wr_bad, hw_bad, set_flt;

  always_comb begin
    next_q   = q;
    tick        = s_tick & ~q.p_tick;
    step_fall   = q.p_step & ~step_n;
    wd_rise     = wd & ~q.p_wd;
    settle_rise = s_settle & ~q.p_settle;
    recal_rise  = s_recal & ~q.p_recal;
    desel       = sel_n & ~q.p_sel_n;
    next_q.p_tick   = s_tick;
    next_q.p_step   = step_n;
    next_q.p_wd     = wd;
    next_q.p_settle = s_settle;
    next_q.p_recal  = s_recal;
    next_q.p_sel_n  = sel_n;
    next_q.recal    = 1'b0;
    next_q.act_step = 1'b0;

    // Spindle period check, one mark per turn
    next_q.mark_n  = ~tick;                                 // [R20]
    next_q.rev_cnt = tick ? 32'h0 :
      ((q.rev_cnt == 32'hFFFF_FFFF) ? q.rev_cnt : q.rev_cnt + 32'h1);
    if (tick) begin
      next_q.spd_good = (q.rev_cnt >= REV_LO) &&
                        (q.rev_cnt <= REV_HI);
    end else if (q.rev_cnt > REV_HI) begin
      next_q.spd_good = 1'b0;                               // [R4]
    end

    // Power-up sequencing
    case (q.st)
      dkif_pkg::DS_OFF: begin
        next_q.motor = s_supply;
        if (s_supply) begin
          next_q.st = dkif_pkg::DS_SPIN;
        end
      end
      dkif_pkg::DS_SPIN: begin
        if (!s_supply) begin
          next_q.st = dkif_pkg::DS_OFF;                     // [R2]
        end else if (q.spd_good) begin
          next_q.st    = dkif_pkg::DS_RECAL;
          next_q.recal = 1'b1;
          next_q.busy  = 1'b1;
        end
      end
      dkif_pkg::DS_RECAL: begin
        if (!s_supply || !q.spd_good) begin
          next_q.st = dkif_pkg::DS_OFF;                     // [R2]
        end else if (recal_rise) begin
          next_q.st   = dkif_pkg::DS_READY;                 // [R1]
          next_q.cyl  = '0;
          next_q.busy = 1'b0;
        end
      end
      dkif_pkg::DS_READY: begin
        if (!q.spd_good) begin
          next_q.st    = dkif_pkg::DS_SHUT;                 // [R4]
          next_q.lock  = 1'b1;
          next_q.motor = 1'b0;
        end else if (!s_supply) begin
          next_q.st = dkif_pkg::DS_OFF;                     // [R2]
        end
      end
      dkif_pkg::DS_SHUT: begin
        // Only a reset leaves this state
        next_q.lock  = 1'b1;
        next_q.motor = 1'b0;
      end
      default: next_q.st = dkif_pkg::DS_OFF;
    endcase
    if (next_q.st == dkif_pkg::DS_OFF) begin
      next_q.motor = 1'b0;
    end

    // Steps only when selected, ready and fault-free
    active = ~sel_n & (q.st == dkif_pkg::DS_READY) & q.flt_n; // [R19] [R15]
    if (active && step_fall) begin                          // [R7]
      next_q.act_step = 1'b1;
      next_q.act_out  = out_dir;                            // [R8]
      next_q.busy     = 1'b1;
      if (out_dir) begin
        next_q.cyl = (q.cyl == '0) ? q.cyl : q.cyl - CYL_W'(1);
      end else begin
        next_q.cyl = (q.cyl == CYL_MAX) ? q.cyl : q.cyl + CYL_W'(1);
      end
    end else if (settle_rise && q.st == dkif_pkg::DS_READY) begin
      next_q.busy = 1'b0;
    end
    next_q.skd_n  = ~((next_q.st == dkif_pkg::DS_READY) &
                      ~next_q.busy);                        // [R5]
    next_q.out0_n = ~(next_q.cyl == '0);                    // [R9]
    next_q.ready_n = ~(next_q.st == dkif_pkg::DS_READY);    // [R1] [R3]
    if (~sel_n && q.flt_n) begin
      next_q.head = head_sel;                               // [R21]
    end

    // Record gate and faults
    attempt = ~sel_n & ~gate_n;                             // [R10]
    next_q.nd_cnt = (!attempt || wd_rise) ? 16'h0 :
      ((q.nd_cnt == 16'hFFFF) ? q.nd_cnt : q.nd_cnt + 16'h1);
    nodata   = q.nd_cnt >= ND_MAX;
    inv_head = 32'(head_sel) >= N_HEADS;
    wr_bad   = s_open | s_short | ~s_wcok | s_offtrk | inv_head |
               ~q.spd_good | q.busy | q.skd_n | q.ready_n |
               s_wprot | nodata;                            // [R13] [R6]
    set_flt  = attempt ? wr_bad : s_hcur;                   // [R14]
    hw_bad   = s_open | s_short | s_offtrk | s_hcur |
               (q.st != dkif_pkg::DS_READY);
    // A new fault wins over the deselect clear
    if (set_flt) begin
      next_q.flt_n = 1'b0;
    end else if (!q.flt_n && desel && !hw_bad) begin
      next_q.flt_n = 1'b1;                                  // [R16]
    end

    next_q.preamp = attempt & next_q.flt_n;                 // [R17]
    next_q.unsafe = attempt & (~s_wcok | nodata);           // [R18]
    if (q.preamp && wd_rise) begin
      next_q.wflux = ~q.wflux;                              // [R11]
    end

    // One playback pulse per read reversal
    next_q.p_flux = s_flux;
    next_q.pb_p   = (s_flux ^ q.p_flux) & ~sel_n & ~q.preamp; // [R12]
    next_q.pb_m   = ~next_q.pb_p;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{st: dkif_pkg::DS_OFF, p_step: 1'b1, p_sel_n: 1'b1,
             ready_n: 1'b1, skd_n: 1'b1, out0_n: 1'b1, flt_n: 1'b1,
             mark_n: 1'b1, pb_m: 1'b1, default: '0};
    end else begin
      q <= next_q;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.drive_ready_n     = q.ready_n;
  assign link.seek_done_n       = q.skd_n;
  assign link.outer_cylinder_n  = q.out0_n;
  assign link.record_fault_n    = q.flt_n;
  assign link.revolution_mark_n = q.mark_n;
  assign link.playback_data_p   = q.pb_p;
  assign link.playback_data_m   = q.pb_m;
  assign motor_on_o             = q.motor;
  assign actuator_lock_o        = q.lock;
  assign recal_o                = q.recal;
  assign actuator_step_o        = q.act_step;
  assign actuator_out_o         = q.act_out;
  assign head_o                 = q.head;
  assign preamp_mode_sel_o      = q.preamp;
  assign write_flux_o           = q.wflux;
  assign unsafe_current_flag_o  = q.unsafe;
endmodule

// ===== hdl/dkif_ctrl.sv
// Controller end: register port, step engine, record strobes
`timescale 1ns/100ps
module dkif_ctrl #(
  parameter int unsigned START_CYC = dkif_pkg::START_CYC,
  parameter int          CYL_W     = dkif_pkg::CYL_W
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  dkif_link_if.ctrl        link,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o
);
  localparam logic [15:0] W_CYC = 16'(dkif_pkg::STEP_W_CYC - 1);
  localparam logic [15:0] G_CYC = 16'(dkif_pkg::STEP_GAP_CYC - 1);

  logic [6:0] ds;
  dkif_sync #(.W(7), .RST_VAL(dkif_pkg::DRV_IN_IDLE)) u_dsync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({link.drive_ready_n, link.seek_done_n,
             link.outer_cylinder_n, link.record_fault_n,
             link.revolution_mark_n, link.playback_data_p,
             link.playback_data_m}),
    .q_o   (ds)
  );
  logic rdy, skd, out0, flt, mark, pb;
  assign {rdy, skd, out0, flt, mark} = ~ds[6:2];
  assign pb = ds[1] & ~ds[0];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic             sel, wen;
    logic [3:0]       head;
    logic [CYL_W-1:0] steps;
    logic [15:0]      tmr;
    logic [31:0]      st_cnt;
    logic             seen_rdy, st_fail;
    logic             p_mark, p_pb;
    logic [15:0]      pb_cnt, rev_cnt;
    logic [31:0]      rdata;
    logic             sel_n, step_n, in_n, gate_n, wd_p, wd_m;
    logic [3:0]       hs_n;
  } dkif_ctl_t;

  dkif_ctl_t q, next_q;
  logic      ok, stepping;

  always_comb begin
    next_q = q;
    next_q.rdata = 32'h0;
    next_q.wd_p  = 1'b0;
    next_q.p_mark = mark;
    next_q.p_pb   = pb;
    stepping = (q.steps != '0) | ~q.step_n;

    if (wr_i) begin
      case (addr_i)
        dkif_pkg::REG_CTRL: begin
          next_q.sel  = wdata_i[dkif_pkg::CTRL_SEL];
          next_q.wen  = wdata_i[dkif_pkg::CTRL_WEN];
          next_q.head = wdata_i[dkif_pkg::CTRL_HEAD +: 4];
        end
        dkif_pkg::REG_SEEK: begin
          next_q.steps = wdata_i[CYL_W-1:0];
          next_q.in_n  = ~wdata_i[dkif_pkg::SEEK_IN];       // [R8]
        end
        dkif_pkg::REG_FLUX: next_q.wd_p = ~q.gate_n;        // [R11]
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        dkif_pkg::REG_CTRL:
          next_q.rdata = {26'h0, q.head, q.wen, q.sel};
        dkif_pkg::REG_SEEK: next_q.rdata = 32'(q.steps);
        dkif_pkg::REG_STAT:
          next_q.rdata = {26'h0, q.st_fail, stepping, flt, out0,
                          skd, rdy};
        dkif_pkg::REG_FLUX: next_q.rdata = {16'h0, q.pb_cnt};
        dkif_pkg::REG_REVS: next_q.rdata = {16'h0, q.rev_cnt};
        default: next_q.rdata = 32'h0;
      endcase
    end

    // Step engine: low pulse then gap per track
    ok = q.sel & rdy;                                       // [R22]
    if (q.tmr != 16'h0) begin
      next_q.tmr = q.tmr - 16'h1;
    end else if (!q.step_n) begin
      next_q.step_n = 1'b1;                                 // [R7]
      next_q.steps  = q.steps - CYL_W'(1);
      next_q.tmr    = G_CYC;
    end else if (q.steps != '0 && ok) begin
      next_q.step_n = 1'b0;
      next_q.tmr    = W_CYC;
    end

    next_q.sel_n  = ~q.sel;                                 // [R19]
    next_q.hs_n   = ~q.head;                                // [R21]
    next_q.gate_n = ~(q.wen & q.sel & rdy & skd & ~stepping &
                      ~flt);                                // [R6] [R10]
    next_q.wd_m   = ~next_q.wd_p;

    // Start-up watchdog on ready
    if (rdy) begin
      next_q.seen_rdy = 1'b1;
    end else if (!q.seen_rdy && !q.st_fail) begin
      next_q.st_cnt = q.st_cnt + 32'h1;
      next_q.st_fail = (q.st_cnt >= START_CYC);             // [R3]
    end
    if (mark && !q.p_mark) begin
      next_q.rev_cnt = q.rev_cnt + 16'h1;
    end
    if (pb && !q.p_pb) begin
      next_q.pb_cnt = q.pb_cnt + 16'h1;                     // [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{sel_n: 1'b1, step_n: 1'b1, in_n: 1'b1, gate_n: 1'b1,
             wd_m: 1'b1, hs_n: 4'hF, default: '0};
    end else begin
      q <= next_q;
    end
  end

  assign rdata_o            = q.rdata;
  assign link.unit_select_n = q.sel_n;
  assign link.step_n        = q.step_n;
  assign link.move_in_n     = q.in_n;
  assign link.head_sel_n    = q.hs_n;
  assign link.record_gate_n = q.gate_n;
  assign link.record_data_p = q.wd_p;
  assign link.record_data_m = q.wd_m;
endmodule

// ===== tb/dkif_props.sv
// Assertions on the drive to controller link
`timescale 1ns/100ps
module dkif_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic unit_select_n,
  input wire logic step_n,
  input wire logic record_gate_n,
  input wire logic record_data_p,
  input wire logic record_data_m,
  input wire logic drive_ready_n,
  input wire logic seek_done_n,
  input wire logic record_fault_n,
  input wire logic revolution_mark_n,
  input wire logic playback_data_p,
  input wire logic playback_data_m
);
  // --------------------
  // Link properties
  // --------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int unsigned low_cnt, next_low_cnt;
  // Step low time
  always_comb begin
    next_low_cnt = (rst_i || step_n) ? 32'h0 : low_cnt + 32'h1;
  end
  always_ff @(posedge clk_i) begin
    low_cnt <= next_low_cnt;
  end
  chk_step_width: assert property (
    $rose(step_n) |-> low_cnt == dkif_pkg::STEP_W_CYC)
    else $error("step width");
  chk_step_ready: assert property (
    $fell(step_n) |-> !unit_select_n && !drive_ready_n)
    else $error("step while idle");
  chk_seek_busy: assert property (
    $fell(step_n) && record_fault_n |-> ##[1:6] seek_done_n)
    else $error("seek done held");
  chk_ready_seek: assert property (
    drive_ready_n && $past(drive_ready_n) |-> seek_done_n)
    else $error("seek done unready");
  chk_gate_ready: assert property (
    $fell(record_gate_n) |-> !unit_select_n && !seek_done_n)
    else $error("gate too early");
  chk_write_pulse: assert property (
    record_data_p |-> !record_data_m ##1 !record_data_p)
    else $error("record pulse");
  chk_play_pulse: assert property (
    playback_data_p |-> !playback_data_m ##1 !playback_data_p)
    else $error("playback pulse");
  chk_mark_pulse: assert property (
    !revolution_mark_n |=> revolution_mark_n)
    else $error("long mark");
  chk_fault_held: assert property (
    !record_fault_n && !unit_select_n |=> !record_fault_n)
    else $error("fault cleared");
  cov_step: cover property ($rose(step_n));
  cov_fault: cover property ($fell(record_fault_n));
  cov_gate: cover property ($fell(record_gate_n));
endmodule

// ===== tb/tb_dkif.sv
// Bench for the drive and controller pair
`timescale 1ns/100ps
module tb_dkif;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o, s, r;
  logic        pwr = 1'b0, spin = 1'b1, tick = 1'b0, srv_idle = 1'b1;
  logic        wcur_ok = 1'b1, hcur = 1'b0, rflux = 1'b0, wprot = 1'b0;
  logic        mot_o, lock_o, recal_o, step_o, out_o, pre_o, flux_o;
  logic        unsafe_o, wf_q, mk_q;
  logic [3:0]  head_o;
  logic [7:0]  srv = 8'h00;
  int          n_step = 0, n_out = 0, n_flux = 0, n_mark = 0, k, o;
  int          bad_count = 0, n_compared = 0;

  dkif_link_if link ();
  dkif_drive #(.REV_CYC(200)) u_dkif_drive (
    .clk_i(clk_i), .rst_i(rst_i), .link(link),
    .supply_good_i(pwr), .spindle_tick_i(tick), .settled_i(srv_idle),
    .recal_done_i(srv_idle), .head_open_i(1'b0), .head_short_i(1'b0),
    .wr_current_ok_i(wcur_ok), .off_track_i(1'b0),
    .head_current_i(hcur), .wr_protect_i(wprot), .read_flux_i(rflux),
    .motor_on_o(mot_o), .actuator_lock_o(lock_o), .recal_o(recal_o),
    .actuator_step_o(step_o), .actuator_out_o(out_o), .head_o(head_o),
    .preamp_mode_sel_o(pre_o), .write_flux_o(flux_o),
    .unsafe_current_flag_o(unsafe_o));
  dkif_ctrl #(.START_CYC(5000)) u_dkif_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .link(link), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  dkif_props u_dkif_props (
    .clk_i(clk_i), .rst_i(rst_i), .unit_select_n(link.unit_select_n),
    .step_n(link.step_n), .record_gate_n(link.record_gate_n),
    .record_data_p(link.record_data_p),
    .record_data_m(link.record_data_m),
    .drive_ready_n(link.drive_ready_n), .seek_done_n(link.seek_done_n),
    .record_fault_n(link.record_fault_n),
    .revolution_mark_n(link.revolution_mark_n),
    .playback_data_p(link.playback_data_p),
    .playback_data_m(link.playback_data_m));

  // --------------------
  // Models
  // --------------------
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Spindle ticks every 200 cycles
  initial begin
    forever begin
      repeat (190) @(posedge clk_i);
      tick <= spin;
      repeat (10) @(posedge clk_i);
      tick <= 1'b0;
    end
  end
  // Servo idle 20 cycles after a kick
  always @(posedge clk_i) begin
    if (step_o === 1'b1 || recal_o === 1'b1) begin
      srv <= 8'h14;
    end else if (srv != 8'h00) begin
      srv <= srv - 8'h01;
    end
    srv_idle <= (srv == 8'h00);
    n_step += (step_o === 1'b1);
    n_out += (step_o === 1'b1 && out_o === 1'b1);
    wf_q <= flux_o;
    n_flux += (flux_o === ~wf_q);
    mk_q <= link.revolution_mark_n;
    n_mark += (mk_q === 1'b1 && link.revolution_mark_n === 1'b0);
  end

  // --------------------
  // Tasks
  // --------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic ctl(input logic [31:0] d);
    wr(dkif_pkg::REG_CTRL, d);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic wait_st(input logic [31:0] m, v);
    int n;
    logic [31:0] t;
    n = 0;
    t = ~v;
    while ((t & m) !== v && n < 2000) begin
      rd(dkif_pkg::REG_STAT, t);
      n++;
    end
    chk("status", t & m, v);
  endtask
  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // --------------------
  // Tests
  // --------------------
  initial begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    pwr <= 1'b1;
    wait_st(32'h2F, 32'h07);
    chk("ready line", link.drive_ready_n, 1'b0);
    ctl(32'h15);
    chk("head lines", link.head_sel_n, 4'hA);
    chk("head", head_o, 4'h5);
    for (int i = 0; i < 2; i++) begin
      k = n_step;
      o = n_out;
      wr(dkif_pkg::REG_SEEK, i ? 32'h3 : 32'h10003);
      repeat (4) @(posedge clk_i);
      wait_st(32'h12, 32'h02);
      chk("steps", n_step - k, 32'h3);
      chk("outward", n_out - o, i ? 32'h3 : 32'h0);
      chk("outer line", link.outer_cylinder_n, !i);
    end
    rd(dkif_pkg::REG_FLUX, s);
    repeat (5) begin
      repeat (10) @(posedge clk_i);
      rflux <= ~rflux;
    end
    repeat (10) @(posedge clk_i);
    rd(dkif_pkg::REG_FLUX, r);
    chk("playback", r - s, 32'h5);
    ctl(32'h03);
    chk("preamp write", pre_o, 1'b1);
    k = n_flux;
    repeat (4) wr(dkif_pkg::REG_FLUX, 32'h0);
    repeat (8) @(posedge clk_i);
    chk("flux", n_flux - k, 32'h4);
    chk("fault line", link.record_fault_n, 1'b1);
    ctl(32'h01);
    chk("preamp read", pre_o, 1'b0);
    @(posedge clk_i) wcur_ok <= 1'b0;
    wr(dkif_pkg::REG_CTRL, 32'h03);
    wait_st(32'h08, 32'h08);
    chk("unsafe", unsafe_o, 1'b1);
    ctl(32'h0B);
    chk("head held", head_o, 4'h0);
    @(posedge clk_i) {wcur_ok, wprot} <= 2'b11;
    ctl(32'h00);
    wait_st(32'h08, 32'h00);
    ctl(32'h03);
    wait_st(32'h08, 32'h08);
    @(posedge clk_i) wprot <= 1'b0;
    ctl(32'h00);
    wait_st(32'h08, 32'h00);
    ctl(32'h01);
    @(posedge clk_i) hcur <= 1'b1;
    wait_st(32'h08, 32'h08);
    @(posedge clk_i) hcur <= 1'b0;
    ctl(32'h00);
    wait_st(32'h08, 32'h00);
    rd(8'h14, r);
    chk("unmapped", r, 32'h0);
    @(negedge tick);
    k = n_mark;
    repeat (3) @(negedge tick);
    chk("marks", n_mark - k, 32'h3);
    spin <= 1'b0;
    repeat (400) @(posedge clk_i);
    chk("motor", mot_o, 1'b0);
    chk("lock", lock_o, 1'b1);
    chk("ready off", link.drive_ready_n, 1'b1);
    finish_test();
  end
endmodule
